// >>> design/tmr8_defines.vh
// Purpose: constants for the 8-bit waveform timer
// Assumes: wishbone classic slave, 32-bit data, byte addresses
// Notes:   offsets, fields, reset values and prescale counts
// What this block does
// - mode 2: counter clears when equal compare A
// - mode 2: compare A flag each top
// - mode 2: late low top wraps via 0xFF
// - mode 2: action 1 toggles output A
// - pin driven only when direction is output
// - mode 2: overflow flag on MAX to 0x00
// - modes 3/7 single slope, top 0xFF or A
// - fast: 2 clears on match, 3 sets
// - fast: clear after top, bottom update there
// - fast: overflow flag at top
// - fast: action 1 toggles A if upper bit
// - fast buffers compare writes, mode 2 direct
// - fast: extreme compare A spike or constant
// - modes 1/5 dual slope, top 0xFF or A
// - dual: non-inverting clears up, sets down
// - dual: top held exactly one tick
// - dual: overflow flag at bottom
// - dual: action 1 toggles A if upper bit
// - dual: extreme compare gives constant level
// - dual: bottom change without match, two cases
// - prescale 1, 8, 64, 256 or 1024
// - match sets channel flag next tick
// - action 0 leaves output state alone
// - reset clears output state registers
`ifndef TMR8_DEFINES_VH
`define TMR8_DEFINES_VH
`define TMR8_ADR_CTRL   4'h0
`define TMR8_ADR_COUNT  4'h1
`define TMR8_ADR_CMPA   4'h2
`define TMR8_ADR_CMPB   4'h3
`define TMR8_ADR_FLAGS  4'h4
`define TMR8_ADR_DIR    4'h5
`define TMR8_F_MODE_LO  0
`define TMR8_F_MODE_HI  2
`define TMR8_F_CLKSEL_LO 3
`define TMR8_F_CLKSEL_HI 5
`define TMR8_F_ACTB_LO  8
`define TMR8_F_ACTB_HI  9
`define TMR8_F_ACTA_LO  10
`define TMR8_F_ACTA_HI  11
`define TMR8_FLAG_OVF   0
`define TMR8_FLAG_CMPA  1
`define TMR8_FLAG_CMPB  2
`define TMR8_MODE_NORMAL 3'h0
`define TMR8_MODE_PC_FF  3'h1
`define TMR8_MODE_CTC    3'h2
`define TMR8_MODE_FP_FF  3'h3
`define TMR8_MODE_PC_A   3'h5
`define TMR8_MODE_FP_A   3'h7
`define TMR8_MAX        8'hFF
`define TMR8_BOTTOM     8'h00
`define TMR8_CTRL_RST   12'h000
`define TMR8_DIV8       10'h007
`define TMR8_DIV64      10'h03F
`define TMR8_DIV256     10'h0FF
`define TMR8_DIV1024    10'h3FF
`endif

// >>> design/tmr8_prescaler.v
// Purpose: timer tick enable from the system clock
// Assumes: select 0 stops, 1..5 divide by 1,8,64,256,1024
// Notes:   one-cycle tick pulse
`timescale 1ns/1ps
`include "tmr8_defines.vh"
module tmr8_prescaler (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rstn,
  // control
  input  wire [2:0] clkSel,
  // tick out
  output reg        tick
);
  reg [9:0] divCnt_reg;
  reg [9:0] limit;

  always @* begin
    case (clkSel)
      3'h2:    limit = `TMR8_DIV8;
      3'h3:    limit = `TMR8_DIV64;
      3'h4:    limit = `TMR8_DIV256;
      3'h5:    limit = `TMR8_DIV1024;
      default: limit = 10'h000;
    endcase
  end

  always @(posedge clk_sys) begin
    if (!rstn) begin
      divCnt_reg <= 10'h000;
      tick       <= 1'b0;
    end else if (clkSel == 3'h0 || clkSel > 3'h5) begin
      divCnt_reg <= 10'h000;
      tick       <= 1'b0;
    end else if (divCnt_reg >= limit) begin
      divCnt_reg <= 10'h000;
      tick       <= 1'b1;
    end else begin
      divCnt_reg <= divCnt_reg + 10'h001;
      tick       <= 1'b0;
    end
  end
endmodule

// >>> design/tmr8_wave_chan.v
// Purpose: one compare channel output state
// Assumes: match and direction already qualified per tick
// Notes:   toggle in PWM modes enabled by parent for channel A only
`timescale 1ns/1ps
`include "tmr8_defines.vh"
module tmr8_wave_chan (
  // clock and reset
  input  wire       clk_sys,
  input  wire       rstn,
  // timing
  input  wire       tick,
  input  wire       match,
  input  wire       atBottom,
  input  wire       atTop,
  input  wire       countUp,
  input  wire       cmpIsTop,
  input  wire       cmpIsZero,
  input  wire       startAbove,
  // configuration
  input  wire [1:0] action,
  input  wire       fastMode,
  input  wire       dualMode,
  input  wire       toggleOk,
  // output state
  output reg        waveState
);
  always @(posedge clk_sys) begin
    if (!rstn) begin
      waveState <= 1'b0;
    end else if (tick && action != 2'b00) begin
      if (action == 2'b01) begin
        if (toggleOk && match)
          waveState <= ~waveState;
      end else if (fastMode) begin
        if (atTop)
          waveState <= ~action[0]; // bottom update
        else if (match && !cmpIsTop)
          waveState <= action[0];
      end else if (dualMode) begin
        if (atBottom && cmpIsZero)
          waveState <= action[0]; // bottom compare holds idle level
        else if (atBottom && startAbove)
          waveState <= ~action[0];
        else if (match && cmpIsTop)
          waveState <= ~action[0]; // as down-match at top
        else if (match)
          waveState <= countUp ? action[0] : ~action[0];
      end else begin
        if (match)
          waveState <= action[0]; // non-pwm clear or set
      end
    end
  end
endmodule

// >>> design/tmr8_timer.v
// Purpose: 8-bit timer with CLEAR_ON_MATCH_MODE, fast and dual-slope PWM
// Assumes: wishbone classic slave, ack one cycle after stb
// Notes:   flags cleared by writing one, set wins
`timescale 1ns/1ps
`include "tmr8_defines.vh"
module tmr8_timer (
  // clock and reset
  input  wire        clk_sys,
  input  wire        rstn,
  // wishbone slave
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  input  wire        wb_we_i,
  input  wire [5:0]  wb_adr_i,
  input  wire [3:0]  wb_sel_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  output wire        wb_ack_o,
  // waveform pins
  output wire        waveOutA,
  output wire        waveOutAOe,
  output wire        waveOutB,
  output wire        waveOutBOe,
  // status
  output wire        overflowFlag,
  output wire        compareAFlag,
  output wire        compareBFlag
);
  reg  [11:0] ctrl_reg;
  reg  [7:0]  count_reg;
  reg  [7:0]  cmpA_reg;
  reg  [7:0]  cmpB_reg;
  reg  [7:0]  cmpABuf_reg;
  reg  [7:0]  cmpBBuf_reg;
  reg  [2:0]  flags_reg;
  reg  [1:0]  dir_reg;
  reg         countUp_reg;
  reg         blockMatch_reg;
  reg         matchA_reg;
  reg         matchB_reg;
  reg         ack_reg;
  reg         aboveA_reg;
  reg         aboveB_reg;
  reg  [7:0]  count_next;
  reg         countUp_next;
  wire        tick;
  wire [2:0]  mode;
  wire [1:0]  actA;
  wire [1:0]  actB;
  wire        fastMode;
  wire        dualMode;
  wire        ctcMode;
  wire        useCmpTop;
  wire [7:0]  topVal;
  wire        atTop;
  wire        atBottom;
  wire        rawMatchA;
  wire        rawMatchB;
  wire        busReq;
  wire        busWr;
  wire [3:0]  regIdx;
  wire        waveA;
  wire        waveB;
  wire        setOvf;
  wire        setCmpA;
  wire        setCmpB;
  wire        upperBit;
  wire        wrCtrl;
  wire        wrCount;
  wire        wrCmpA;
  wire        wrCmpB;
  wire        wrFlags;
  wire        wrDir;
  wire        clrOvf;
  wire        clrCmpA;
  wire        clrCmpB;
  wire        cmpAIsTop;
  wire        cmpAIsZero;
  wire        cmpBIsTop;
  wire        cmpBIsZero;
  wire        toggleOkA;
  wire        toggleOkB;
  reg         ovfEvent;
  reg  [31:0] readWord;

  // byte-lane write merge
  function [7:0] laneByte;
    input [31:0] data;
    input [3:0]  sel;
    input [7:0]  old;
    input [1:0]  lane;
    begin
      laneByte = sel[lane] ? data[lane*8 +: 8] : old;
    end
  endfunction

  // register select for a taken write
  function regHit;
    input       wrTaken;
    input [3:0] idx;
    input [3:0] want;
    begin
      regHit = wrTaken && (idx == want);
    end
  endfunction

  // write-one-to-clear flag, set wins
  function nextFlag;
    input setEv;
    input oldVal;
    input clrReq;
    begin
      nextFlag = setEv | (oldVal & ~clrReq);
    end
  endfunction

  assign mode      = ctrl_reg[`TMR8_F_MODE_HI:`TMR8_F_MODE_LO];
  assign actA      = ctrl_reg[`TMR8_F_ACTA_HI:`TMR8_F_ACTA_LO];
  assign actB      = ctrl_reg[`TMR8_F_ACTB_HI:`TMR8_F_ACTB_LO];
  assign upperBit  = mode[2];
  assign ctcMode   = (mode == `TMR8_MODE_CTC);
  assign fastMode  = (mode == `TMR8_MODE_FP_FF) || (mode == `TMR8_MODE_FP_A);
  assign dualMode  = (mode == `TMR8_MODE_PC_FF) || (mode == `TMR8_MODE_PC_A);
  assign useCmpTop = ctcMode || (mode == `TMR8_MODE_FP_A) || (mode == `TMR8_MODE_PC_A);
  assign topVal    = useCmpTop ? cmpA_reg : `TMR8_MAX;
  assign atTop     = (count_reg == topVal);
  assign atBottom  = (count_reg == `TMR8_BOTTOM);
  assign rawMatchA = (count_reg == cmpA_reg) && !blockMatch_reg;
  assign rawMatchB = (count_reg == cmpB_reg) && !blockMatch_reg;

  assign busReq = wb_cyc_i && wb_stb_i && !ack_reg;
  assign busWr  = busReq && wb_we_i;
  assign regIdx = wb_adr_i[5:2];
  assign wb_ack_o = ack_reg;

  assign wrCtrl     = regHit(busWr, regIdx, `TMR8_ADR_CTRL);
  assign wrCount    = regHit(busWr, regIdx, `TMR8_ADR_COUNT);
  assign wrCmpA     = regHit(busWr, regIdx, `TMR8_ADR_CMPA);
  assign wrCmpB     = regHit(busWr, regIdx, `TMR8_ADR_CMPB);
  assign wrFlags    = regHit(busWr, regIdx, `TMR8_ADR_FLAGS);
  assign wrDir      = regHit(busWr, regIdx, `TMR8_ADR_DIR);
  assign clrOvf     = wrFlags && wb_sel_i[0] && wb_dat_i[`TMR8_FLAG_OVF];
  assign clrCmpA    = wrFlags && wb_sel_i[0] && wb_dat_i[`TMR8_FLAG_CMPA];
  assign clrCmpB    = wrFlags && wb_sel_i[0] && wb_dat_i[`TMR8_FLAG_CMPB];
  assign cmpAIsTop  = (cmpA_reg == `TMR8_MAX);
  assign cmpAIsZero = (cmpA_reg == `TMR8_BOTTOM);
  assign cmpBIsTop  = (cmpB_reg == `TMR8_MAX);
  assign cmpBIsZero = (cmpB_reg == `TMR8_BOTTOM);
  assign toggleOkA  = !(fastMode || dualMode) || upperBit;
  assign toggleOkB  = !(fastMode || dualMode);

  tmr8_prescaler uPresc (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .clkSel  (ctrl_reg[`TMR8_F_CLKSEL_HI:`TMR8_F_CLKSEL_LO]),
    .tick    (tick)
  );

  // counter sequence
  always @* begin
    count_next   = count_reg;
    countUp_next = countUp_reg;
    if (dualMode) begin
      if (countUp_reg) begin
        if (atTop) begin
          countUp_next = 1'b0;
          count_next   = count_reg - 8'h01;
        end else begin
          count_next = count_reg + 8'h01;
        end
      end else if (atBottom) begin
        countUp_next = 1'b1;
        count_next   = count_reg + 8'h01;
      end else begin
        count_next = count_reg - 8'h01;
      end
    end else if ((fastMode || ctcMode) && atTop) begin
      count_next   = `TMR8_BOTTOM;
      countUp_next = 1'b1;
    end else begin
      count_next   = count_reg + 8'h01; // wraps through MAX
      countUp_next = 1'b1;
    end
  end

  // flag sources
  always @* begin
    case (mode)
      `TMR8_MODE_PC_FF,
      `TMR8_MODE_PC_A: ovfEvent = atBottom && !countUp_reg;
      `TMR8_MODE_FP_FF,
      `TMR8_MODE_FP_A: ovfEvent = atTop;
      default:         ovfEvent = (count_reg == `TMR8_MAX);
    endcase
  end
  assign setOvf  = tick && ovfEvent;
  assign setCmpA = tick && matchA_reg; // one tick after match
  assign setCmpB = tick && matchB_reg;

  // count, direction, match block, buffers
  always @(posedge clk_sys) begin
    if (!rstn) begin
      count_reg      <= `TMR8_BOTTOM;
      countUp_reg    <= 1'b1;
      blockMatch_reg <= 1'b0;
      cmpA_reg       <= `TMR8_BOTTOM;
      cmpB_reg       <= `TMR8_BOTTOM;
      aboveA_reg     <= 1'b0;
      aboveB_reg     <= 1'b0;
    end else begin
      if (wrCount && wb_sel_i[0]) begin
        count_reg      <= wb_dat_i[7:0];
        countUp_reg    <= 1'b1;
        blockMatch_reg <= 1'b1;
        aboveA_reg     <= (wb_dat_i[7:0] > cmpA_reg); // start above
        aboveB_reg     <= (wb_dat_i[7:0] > cmpB_reg);
      end else if (tick) begin
        count_reg      <= count_next;
        countUp_reg    <= countUp_next;
        blockMatch_reg <= 1'b0;
        if (atBottom) begin
          aboveA_reg <= 1'b0;
          aboveB_reg <= 1'b0;
        end
      end
      if (!(fastMode || dualMode)) begin
        cmpA_reg <= cmpABuf_reg; // direct in non-pwm
        cmpB_reg <= cmpBBuf_reg;
      end else if (tick && (fastMode ? atTop : (atTop && countUp_reg))) begin
        cmpA_reg <= cmpABuf_reg; // update at bottom or top
        cmpB_reg <= cmpBBuf_reg;
      end
    end
  end

  // registered match for flag timing
  always @(posedge clk_sys) begin
    if (!rstn) begin
      matchA_reg <= 1'b0;
      matchB_reg <= 1'b0;
    end else if (tick) begin
      matchA_reg <= rawMatchA;
      matchB_reg <= rawMatchB;
    end
  end

  // register writes and flags
  always @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl_reg    <= `TMR8_CTRL_RST;
      cmpABuf_reg <= `TMR8_BOTTOM;
      cmpBBuf_reg <= `TMR8_BOTTOM;
      flags_reg   <= 3'b000;
      dir_reg     <= 2'b00;
    end else begin
      if (wrCtrl) begin
        ctrl_reg[7:0]  <= laneByte(wb_dat_i, wb_sel_i, ctrl_reg[7:0], 2'd0);
        ctrl_reg[11:8] <= wb_sel_i[1] ? wb_dat_i[11:8] : ctrl_reg[11:8];
      end
      if (wrCmpA)
        cmpABuf_reg <= laneByte(wb_dat_i, wb_sel_i, cmpABuf_reg, 2'd0);
      if (wrCmpB)
        cmpBBuf_reg <= laneByte(wb_dat_i, wb_sel_i, cmpBBuf_reg, 2'd0);
      if (wrDir && wb_sel_i[0])
        dir_reg <= wb_dat_i[1:0];
      flags_reg[`TMR8_FLAG_OVF]  <= nextFlag(setOvf, flags_reg[`TMR8_FLAG_OVF], clrOvf);
      flags_reg[`TMR8_FLAG_CMPA] <= nextFlag(setCmpA, flags_reg[`TMR8_FLAG_CMPA], clrCmpA);
      flags_reg[`TMR8_FLAG_CMPB] <= nextFlag(setCmpB, flags_reg[`TMR8_FLAG_CMPB], clrCmpB);
    end
  end

  // read data select
  always @* begin
    case (regIdx)
      `TMR8_ADR_CTRL:  readWord = {20'h00000, ctrl_reg};
      `TMR8_ADR_COUNT: readWord = {24'h000000, count_reg};
      `TMR8_ADR_CMPA:  readWord = {24'h000000, cmpABuf_reg};
      `TMR8_ADR_CMPB:  readWord = {24'h000000, cmpBBuf_reg};
      `TMR8_ADR_FLAGS: readWord = {26'h0000000, countUp_reg, waveB, waveA,
                                   flags_reg};
      `TMR8_ADR_DIR:   readWord = {30'h00000000, dir_reg};
      default:         readWord = 32'h00000000;
    endcase
  end

  // bus answer
  always @(posedge clk_sys) begin
    if (!rstn) begin
      ack_reg  <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else begin
      ack_reg <= busReq;
      if (busReq && !wb_we_i)
        wb_dat_o <= readWord;
    end
  end

  // waveform channels
  tmr8_wave_chan uChanA (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .tick       (tick),
    .match      (rawMatchA),
    .atBottom   (atBottom),
    .atTop      (atTop),
    .countUp    (countUp_reg),
    .cmpIsTop   (cmpAIsTop),
    .cmpIsZero  (cmpAIsZero),
    .startAbove (aboveA_reg),
    .action     (actA),
    .fastMode   (fastMode),
    .dualMode   (dualMode),
    .toggleOk   (toggleOkA),
    .waveState  (waveA)
  );

  tmr8_wave_chan uChanB (
    .clk_sys    (clk_sys),
    .rstn       (rstn),
    .tick       (tick),
    .match      (rawMatchB),
    .atBottom   (atBottom),
    .atTop      (atTop),
    .countUp    (countUp_reg),
    .cmpIsTop   (cmpBIsTop),
    .cmpIsZero  (cmpBIsZero),
    .startAbove (aboveB_reg),
    .action     (actB),
    .fastMode   (fastMode),
    .dualMode   (dualMode),
    .toggleOk   (toggleOkB),
    .waveState  (waveB)
  );

  // pin drive
  assign waveOutA     = waveA;
  assign waveOutAOe   = dir_reg[0] && (actA != 2'b00);
  assign waveOutB     = waveB;
  assign waveOutBOe   = dir_reg[1] && (actB != 2'b00);
  assign overflowFlag = flags_reg[`TMR8_FLAG_OVF];
  assign compareAFlag = flags_reg[`TMR8_FLAG_CMPA];
  assign compareBFlag = flags_reg[`TMR8_FLAG_CMPB];
endmodule

// >>> tb/tmr8_pin_model.sv
// Purpose: port pin seen from outside the timer
// Assumes: pull-up on the pad
// Notes:   released pin floats high
`timescale 1ns/1ps
module tmr8_pin_model (
  // drive side
  input  wire logic waveOut,
  input  wire logic waveOe,
  // pad
  output wire logic pinLevel
);
  // pad level only follows the timer while driven
  assign pinLevel = waveOe ? waveOut : 1'b1;
endmodule

// >>> tb/tmr8_timer_monitor.sv
// Purpose: port-level checks of the waveform timer
// Assumes: classic wishbone, one clock
// Notes:   shadows control and direction writes
`timescale 1ns/1ps
module tmr8_timer_monitor (
  // clock and reset
  input logic        clk_sys,
  input logic        rstn,
  // wishbone
  input logic        wb_cyc_i,
  input logic        wb_stb_i,
  input logic        wb_we_i,
  input logic [5:0]  wb_adr_i,
  input logic [3:0]  wb_sel_i,
  input logic [31:0] wb_dat_i,
  input logic [31:0] wb_dat_o,
  input logic        wb_ack_o,
  // pins and flags
  input logic        waveOutA,
  input logic        waveOutAOe,
  input logic        waveOutB,
  input logic        waveOutBOe,
  input logic        overflowFlag,
  input logic        compareAFlag,
  input logic        compareBFlag
);
  logic [11:0] ctrl_reg;
  logic [1:0]  dir_reg;
  logic        wrTake;
  logic        clrA;
  logic        stopped;
  logic        aHold;
  logic        bHold;
  assign wrTake = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
  assign clrA = wrTake && wb_adr_i[5:2] == 4'h4 && wb_sel_i[0] && wb_dat_i[1];
  assign stopped = ctrl_reg[5:3] == 3'h0;
  assign aHold = (ctrl_reg[2:0] == 3'h1 || ctrl_reg[2:0] == 3'h3) && ctrl_reg[11:10] == 2'h1;
  assign bHold = ctrl_reg[0] && ctrl_reg[9:8] == 2'h1;
  // shadow of control and direction
  always @(posedge clk_sys) begin
    if (!rstn) begin
      ctrl_reg <= 12'h000;
      dir_reg  <= 2'h0;
    end else if (wrTake) begin
      if (wb_adr_i[5:2] == 4'h0 && wb_sel_i[0]) ctrl_reg[7:0] <= wb_dat_i[7:0];
      if (wb_adr_i[5:2] == 4'h0 && wb_sel_i[1]) ctrl_reg[11:8] <= wb_dat_i[11:8];
      if (wb_adr_i[5:2] == 4'h5 && wb_sel_i[0]) dir_reg <= wb_dat_i[1:0];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence reqTaken;
    wb_cyc_i && wb_stb_i && !wb_ack_o;
  endsequence
  sequence ackPulse;
    wb_ack_o ##1 !wb_ack_o;
  endsequence
  AST_ACK_PULSE:
    assert property (reqTaken |=> ackPulse) else $error("ack not one pulse after request");
  AST_PIN_EN_A:
    assert property (waveOutAOe == (dir_reg[0] && ctrl_reg[11:10] != 2'h0))
      else $error("pin A enable wrong");
  AST_PIN_EN_B:
    assert property (waveOutBOe == (dir_reg[1] && ctrl_reg[9:8] != 2'h0))
      else $error("pin B enable wrong");
  AST_RESET_CLEAR:
    assert property (disable iff (1'b0) !rstn |=> !waveOutA && !waveOutB && !overflowFlag)
      else $error("reset left output state set");
  AST_NO_ACTION_A:
    assert property (!$stable(waveOutA) |-> $past(ctrl_reg[11:10]) != 2'h0)
      else $error("output A moved with action zero");
  AST_NO_TOGGLE_A:
    assert property ($past(aHold) |-> $stable(waveOutA)) else $error("output A toggled");
  AST_NO_TOGGLE_B:
    assert property ($past(bHold) |-> $stable(waveOutB)) else $error("output B toggled");
  AST_FLAG_A_STICKY:
    assert property ($fell(compareAFlag) |-> $past(clrA)) else $error("compare A flag lost");
  AST_STOP_NO_FLAG:
    assert property (stopped && $past(stopped) && $past(stopped, 2) && $past(stopped, 3)
      |-> !$rose(overflowFlag) && !$rose(compareAFlag)) else $error("flag set while stopped");
endmodule
bind tmr8_timer tmr8_timer_monitor mon (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
  .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .waveOutA(waveOutA),
  .waveOutAOe(waveOutAOe), .waveOutB(waveOutB), .waveOutBOe(waveOutBOe),
  .overflowFlag(overflowFlag), .compareAFlag(compareAFlag), .compareBFlag(compareBFlag));

// >>> tb/tmr8_timer_test.sv
// Purpose: self-checking bench of the waveform timer
// Assumes: 200 MHz clock, classic wishbone master
// Notes:   waveforms judged by high time and edge count
`timescale 1ns/1ps
`include "tmr8_defines.vh"
module tmr8_timer_test;
  logic        clk_sys, rstn, cyc, stb, we;
  logic [5:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat;
  wire  [31:0] rdat;
  wire         ack, waveOutA, waveOutAOe, waveOutB, waveOutBOe, ovf, cmpAF, cmpBF, pinA, pinB;
  int          err_count;
  int          n_tests;
  always #2.5 clk_sys = ~clk_sys;
  tmr8_timer uut (.clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
    .wb_ack_o(ack), .waveOutA(waveOutA), .waveOutAOe(waveOutAOe), .waveOutB(waveOutB),
    .waveOutBOe(waveOutBOe), .overflowFlag(ovf), .compareAFlag(cmpAF), .compareBFlag(cmpBF));
  tmr8_pin_model pinModelA (.waveOut(waveOutA), .waveOe(waveOutAOe), .pinLevel(pinA));
  tmr8_pin_model pinModelB (.waveOut(waveOutB), .waveOe(waveOutBOe), .pinLevel(pinB));
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[ERR] %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task tally_and_finish;
    if (err_count == 0 && n_tests > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task xfer(input logic wr, input logic [3:0] idx, input logic [31:0] d, output logic [31:0] q);
    int t;
    @(posedge clk_sys);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= wr;
    adr <= {idx, 2'b00};
    sel <= 4'hF;
    wdat <= d;
    t = 0;
    do begin
      @(posedge clk_sys);
      t++;
    end while (ack !== 1'b1 && t < 40);
    q = rdat;
    chk(ack, 1'b1);
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task wr(input logic [3:0] idx, input logic [31:0] d);
    logic [31:0] q;
    xfer(1'b1, idx, d, q);
  endtask
  function logic [31:0] ctl(input logic [2:0] m, input logic [2:0] cs, input logic [1:0] b,
                            input logic [1:0] a);
    return {20'h0, a, b, 2'b00, cs, m};
  endfunction
  task cfg(input logic [7:0] ca, input logic [7:0] cb, input logic [31:0] c);
    wr(`TMR8_ADR_CTRL, 32'h0);
    wr(`TMR8_ADR_COUNT, 32'h0);
    wr(`TMR8_ADR_CMPA, {24'h0, ca});
    wr(`TMR8_ADR_CMPB, {24'h0, cb});
    wr(`TMR8_ADR_FLAGS, 32'h7);
    wr(`TMR8_ADR_CTRL, c);
  endtask
  // high cycles and level changes over a window
  task meas(input logic useB, input int settle, input int n, input int eHi, input int eCh);
    int hi, ch;
    logic prev, cur;
    repeat (settle) @(posedge clk_sys);
    hi = 0;
    ch = 0;
    prev = useB ? waveOutB : waveOutA;
    repeat (n) begin
      @(posedge clk_sys);
      cur = useB ? waveOutB : waveOutA;
      if (cur === 1'b1) hi++;
      if (cur !== prev) ch++;
      prev = cur;
    end
    chk(hi, eHi);
    chk(ch, eCh);
  endtask
  task t_regs;
    logic [31:0] q;
    chk(waveOutA, 1'b0);
    chk(waveOutB, 1'b0);
    xfer(1'b0, `TMR8_ADR_CTRL, 32'h0, q);
    chk(q, 32'h0);
    wr(`TMR8_ADR_DIR, 32'h3);
    xfer(1'b0, `TMR8_ADR_DIR, 32'h0, q);
    chk(q[1:0], 2'h3);
    xfer(1'b0, 4'hF, 32'h0, q);
    chk(q, 32'h0);
  endtask
  task t_ctc;
    wr(`TMR8_ADR_DIR, 32'h0);
    cfg(8'h03, 8'h00, ctl(3'h2, 3'h1, 2'h0, 2'h1));
    meas(1'b0, 20, 64, 32, 16);
    chk(pinA, 1'b1);
    wr(`TMR8_ADR_DIR, 32'h3);
    chk(pinA, waveOutA);
    chk(cmpAF, 1'b1);
    chk(ovf, 1'b0);
    cfg(8'hC8, 8'h00, ctl(3'h2, 3'h1, 2'h0, 2'h0));
    repeat (100) @(posedge clk_sys);
    wr(`TMR8_ADR_CMPA, 32'h5);
    wr(`TMR8_ADR_FLAGS, 32'h1);
    chk(ovf, 1'b0);
    repeat (170) @(posedge clk_sys);
    chk(ovf, 1'b1);
  endtask
  task t_prescale;
    int divs[5];
    divs = '{1, 8, 64, 256, 1024};
    for (int s = 1; s <= 5; s++) begin
      cfg(8'h00, 8'h00, ctl(3'h2, s[2:0], 2'h0, 2'h1));
      meas(1'b0, 2 * divs[s-1] + 20, 4 * divs[s-1], 2 * divs[s-1], 4);
    end
  endtask
  task t_fast;
    cfg(8'h40, 8'h00, ctl(3'h3, 3'h1, 2'h0, 2'h2));
    meas(1'b0, 300, 512, 130, 4);
    chk(ovf, 1'b1);
    cfg(8'h40, 8'h00, ctl(3'h3, 3'h1, 2'h0, 2'h3));
    meas(1'b0, 300, 512, 382, 4);
    cfg(8'hFF, 8'h00, ctl(3'h3, 3'h1, 2'h0, 2'h2));
    meas(1'b0, 300, 512, 512, 0);
    cfg(8'h00, 8'h00, ctl(3'h3, 3'h1, 2'h0, 2'h2));
    meas(1'b0, 300, 512, 2, 4);
    cfg(8'h09, 8'h00, ctl(3'h7, 3'h1, 2'h0, 2'h1));
    meas(1'b0, 40, 200, 100, 20);
    cfg(8'h40, 8'h00, ctl(3'h3, 3'h1, 2'h1, 2'h0));
    meas(1'b1, 20, 300, 0, 0);
    chk(pinB, 1'b0);
  endtask
  task t_dual;
    cfg(8'h40, 8'h00, ctl(3'h1, 3'h1, 2'h0, 2'h2));
    meas(1'b0, 600, 1020, 256, 4);
    chk(ovf, 1'b1);
    cfg(8'h40, 8'h00, ctl(3'h1, 3'h1, 2'h0, 2'h3));
    meas(1'b0, 600, 1020, 764, 4);
    cfg(8'h00, 8'h00, ctl(3'h1, 3'h1, 2'h0, 2'h2));
    meas(1'b0, 600, 600, 0, 0);
    cfg(8'hFF, 8'h00, ctl(3'h1, 3'h1, 2'h0, 2'h2));
    meas(1'b0, 600, 600, 600, 0);
    cfg(8'd20, 8'd5, ctl(3'h5, 3'h1, 2'h2, 2'h0));
    meas(1'b1, 100, 80, 20, 4);
    chk(cmpBF, 1'b1);
    cfg(8'h40, 8'h00, ctl(3'h1, 3'h1, 2'h0, 2'h1));
    meas(1'b0, 20, 300, 300, 0);
  endtask
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_count++;
    tally_and_finish;
  end
  initial begin
    clk_sys = 1'b0;
    rstn = 1'b0;
    cyc = 1'b0;
    stb = 1'b0;
    we = 1'b0;
    adr = 6'h00;
    sel = 4'h0;
    wdat = 32'h0;
    err_count = 0;
    n_tests = 0;
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    t_regs;
    t_ctc;
    t_prescale;
    t_fast;
    t_dual;
    tally_and_finish;
  end
endmodule
